// >>> bench/sew_chk.sv
// Purpose: Port-level assertions for the serial EEPROM slave.
// Assumes: The bench holds the mode and protect pins steady around register reads.
// Notes:   Bound into sew_top after the module.
`timescale 1ns/10ps
module sew_chk
	import sew_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  scl,
	input  wire logic                  sdaOe,
	input  wire logic                  writeModeSel,
	input  wire logic                  writeProtect,
	input  wire logic [REG_ADDR_W-1:0] regAddr,
	input  wire logic                  regRd,
	input  wire logic [REG_DATA_W-1:0] regRdData
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [6:0] oeCnt_q;
	// Counts how long the device keeps the data line pulled low.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			oeCnt_q <= 7'h00;
		end else begin
			oeCnt_q <= sdaOe ? oeCnt_q + 7'h01 : 7'h00;
		end
	end
	oe_clk_low_a: assert property ($changed(sdaOe) |-> !$past(scl, 2))
		else $error("data line changed while serial clock high");
	oe_hold_bound_a: assert property (oeCnt_q <= 7'h50)
		else $error("data line held low too long");
	busy_quiet_a: assert property ($past(regRd) && $past(regAddr) == REG_STATUS
		&& regRdData[STAT_BUSY_BIT] |-> !sdaOe && !$past(sdaOe)) else $error("drive while busy");
	prot_status_a: assert property ($past(regRd) && $past(regAddr) == REG_STATUS
		&& $past(writeProtect, 4) && $past(writeProtect, 8) |-> regRdData[STAT_PROT_BIT])
		else $error("protect bit not shown");
	mode_status_a: assert property ($past(regRd) && $past(regAddr) == REG_STATUS
		&& $past(writeModeSel, 4) == $past(writeModeSel, 8)
		|-> regRdData[STAT_MODE_BIT] == $past(writeModeSel, 4)) else $error("mode bit wrong");
	rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == '0)
		else $error("read data outside read cycle");
	unmapped_zero_a: assert property ($past(regRd) && $past(regAddr) != REG_STATUS
		&& $past(regAddr) != REG_CTRL |-> regRdData == '0) else $error("unmapped read");
	ctrl_spare_a: assert property ($past(regRd) && $past(regAddr) == REG_CTRL
		|-> regRdData[REG_DATA_W-1:1] == '0) else $error("control spare bits set");
	cover property ($rose(sdaOe));
	cover property (oeCnt_q == 7'h08);
	cover property ($past(regRd) && $past(regAddr) == REG_STATUS && regRdData[STAT_BUSY_BIT]);
endmodule : sew_chk

bind sew_top sew_chk i_sew_chk (
	.mclk(mclk), .rst(rst), .scl(scl), .sdaOe(sdaOe), .writeModeSel(writeModeSel),
	.writeProtect(writeProtect), .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData)
);

// >>> bench/sew_mst.sv
// Purpose: Behavioural two-wire bus master facing the EEPROM slave.
// Assumes: The bench resolves the data line with a pull-up.
// Notes:   One bit is eight mclk cycles; the clock idles high between frames.
`timescale 1ns/10ps
module sew_mst (
	input  wire logic mclk,
	input  wire logic sdaIn,
	output logic      scl,
	output logic      sdaPull
);
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end
	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// Start (isStop low) or stop condition while the clock is high.
	task cond(input logic isStop);
		sdaPull <= isStop;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sdaPull <= ~isStop;
		tick(4);
		if (!isStop) begin
			scl <= 1'b0;
			tick(1);
		end
	endtask : cond
	// Data moves one cycle after the clock falls and the clock rises four cycles later.
	// The slave answers four cycles after a fall, so its data never meets a clock edge.
	task bitx(input logic b, output logic r);
		sdaPull <= ~b;
		tick(4);
		scl <= 1'b1;
		tick(3);
		r = sdaIn;
		scl <= 1'b0;
		tick(1);
	endtask : bitx
	task wrByte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask : wrByte
	// Master acknowledge asks for the next byte; none ends the read.
	task rdByte(input logic mAck, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			b[i] = r;
		end
		bitx(~mAck, r);
	endtask : rdByte
endmodule : sew_mst

// >>> bench/sew_top_tb.sv
// Purpose: Self-checking bench of the serial EEPROM slave.
// Assumes: Shortened program time; serial clock of 320 ns.
// Notes:   A reference array holds the expected memory content.
`timescale 1ns/10ps
module sew_top_tb
	import sew_pkg::*;
;
	localparam int PT = 200;
	logic mclk, rst, modeSel, protIn, regWr, regRd;
	logic [2:0] chipSel;
	logic [7:0] regAddr, a, b, ctr;
	logic [31:0] regWrData, regRdData, d, seedV;
	logic scl, sdaPull, sdaOut, sdaOe, ack, prot;
	logic [7:0] mem [256];
	int err_count = 0, checked = 0, nk;
	wire sdaLine = ~sdaPull & (~sdaOe | sdaOut);
	always #20 mclk = ~mclk;
	sew_top #(.PROG_TIME_CYC(PT)) i_sew_top (.mclk(mclk), .rst(rst), .scl(scl),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelect(chipSel),
		.writeModeSel(modeSel), .writeProtect(protIn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
	sew_mst i_sew_mst (.mclk(mclk), .sdaIn(sdaLine), .scl(scl), .sdaPull(sdaPull));
	task report_and_stop;
		$display("mismatches %0d comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	task ckVal(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : ckVal
	task ckAck(input string n, input logic e, input logic s);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %b seen %b", n, e, s);
		end
	endtask : ckAck
	function automatic logic [7:0] selB(input logic [2:0] c, input logic r);
		return {DEV_TYPE_CODE, c, r};
	endfunction : selB
	function automatic logic [7:0] nextA(input logic [7:0] s, input int i, input logic m);
		return m ? s + 8'(i) : {s[7:3], s[2:0] + 3'(i)};
	endfunction : nextA
	task rw(input logic [7:0] ad, input logic [31:0] wd);
		@(posedge mclk) {regAddr, regWrData, regWr} <= {ad, wd, 1'b1};
		@(posedge mclk) regWr <= 1'b0;
	endtask : rw
	task rr(input logic [7:0] ad);
		@(posedge mclk) {regAddr, regRd} <= {ad, 1'b1};
		@(posedge mclk) regRd <= 1'b0;
		#1 d = regRdData;
	endtask : rr
	task wr(input logic [7:0] s, input int n, input logic m);
		@(posedge mclk) modeSel <= m;
		i_sew_mst.cond(1'b0);
		i_sew_mst.wrByte(selB(chipSel, 1'b0), ack);
		ckAck("selAck", 1'b1, ack);
		i_sew_mst.wrByte(s, ack);
		ckAck("addrAck", 1'b1, ack);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			i_sew_mst.wrByte(b, ack);
			ckAck("dataAck", 1'b1, ack);
			if (!prot) mem[nextA(s, i, m)] = b;
		end
		i_sew_mst.cond(1'b1);
	endtask : wr
	task poll;
		@(posedge mclk);
		nk = 0;
		ack = 1'b0;
		while (!ack && nk < 12) begin
			i_sew_mst.cond(1'b0);
			i_sew_mst.wrByte(selB(chipSel, 1'b0), ack);
			if (!ack) nk++;
		end
		i_sew_mst.cond(1'b1);
	endtask : poll
	task rd(input logic [7:0] s, input int n, input logic rnd, input logic ext);
		@(posedge mclk) modeSel <= 1'($urandom);
		if (rnd) begin
			i_sew_mst.cond(1'b0);
			i_sew_mst.wrByte(selB(chipSel, 1'b0), ack);
			i_sew_mst.wrByte(s, ack);
			ctr = s;
		end
		i_sew_mst.cond(1'b0);
		i_sew_mst.wrByte(selB(chipSel, 1'b1), ack);
		ckAck("rdSelAck", 1'b1, ack);
		for (int i = 0; i < n; i++) begin
			i_sew_mst.rdByte(i < n - 1, b);
			ckVal("rdData", 32'(mem[ctr]), 32'(b));
			ctr++;
		end
		if (ext) i_sew_mst.rdByte(1'b0, b);
		if (ext) ckVal("released", 32'hFF, 32'(b));
		i_sew_mst.cond(1'b1);
	endtask : rd
	initial begin
		#3000000;
		err_count++;
		report_and_stop();
	end
	initial begin
		seedV = $urandom(32'hF11A4D37);
		mclk = 1'b0;
		rst = 1'b1;
		{modeSel, protIn, regWr, regRd} = 4'h0;
		{chipSel, regAddr, regWrData} = '0;
		prot = 1'b0;
		for (int i = 0; i < 256; i++) mem[i] = MEM_RESET_VAL;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		chipSel <= 3'($urandom);
		repeat (4) @(posedge mclk);
		rr(REG_CTRL);
		ckVal("ctrlReset", 32'h0, d);
		rr(8'h08);
		ckVal("unmapped", 32'h0, d);
		rd(8'($urandom), 2, 1'b1, 1'b0);
		for (int m = 0; m < 2; m++) begin
			a = 8'($urandom);
			wr(a, 1, m[0]);
			rr(REG_STATUS);
			ckAck("busy", 1'b1, d[STAT_BUSY_BIT]);
			poll();
			ckAck("pollNack", 1'b1, nk > 0 && nk < 4);
			rd(a, 1, 1'b1, 1'b0);
		end
		a = 8'($urandom);
		wr(a, 10, 1'b0);
		poll();
		rd({a[7:3], 3'h0}, 8, 1'b1, 1'b0);
		for (int s = 0; s < 2; s++) begin
			a = {a[7:3] + 5'h1, s[0] ? 3'h6 : 3'h0};
			wr(a, 4, 1'b1);
			poll();
			ckAck("spanWait", s[0], nk >= 4);
			rd(a, 4, 1'b1, 1'b0);
		end
		@(posedge mclk) protIn <= 1'b1;
		prot = 1'b1;
		repeat (10) @(posedge mclk);
		rr(REG_STATUS);
		ckAck("protBit", 1'b1, d[STAT_PROT_BIT]);
		wr(a, 2, 1'b0);
		poll();
		ckVal("protPoll", 32'h0, 32'(nk));
		@(posedge mclk) protIn <= 1'b0;
		rw(REG_CTRL, 32'h1);
		rr(REG_CTRL);
		ckVal("ctrl", 32'h1, d);
		wr(a, 2, 1'b1);
		rd(a, 2, 1'b1, 1'b0);
		rw(REG_CTRL, 32'h0);
		prot = 1'b0;
		for (int c = 0; c < 8; c++) begin
			i_sew_mst.cond(1'b0);
			i_sew_mst.wrByte(selB(3'(c), 1'b0), ack);
			i_sew_mst.cond(1'b1);
			ckAck("csMatch", 3'(c) == chipSel, ack);
		end
		wr(8'h02, 1, 1'b0);
		poll();
		rd(8'hFE, 1, 1'b1, 1'b0);
		rd(8'h00, 2, 1'b0, 1'b0);
		rd(8'hFF, 3, 1'b1, 1'b1);
		report_and_stop();
	end
endmodule : sew_top_tb

// >>> verilog/sew_pin_sync.sv
// Purpose: Two-flop synchroniser with edge detection for slow pins.
// Assumes: Inputs are asynchronous to mclk.
// Notes:   Level, rise and fall are aligned to the same clock edge.
`timescale 1ns/10ps
module sew_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;
	logic [2:0]   fill_q;
	wire          armed = fill_q[2];

	// Edges stay quiet until the pipeline holds real pin levels, so reset makes no false edge.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
			fill_q <= 3'h0;
			rise   <= '0;
			fall   <= '0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
			prev_q <= sync_q;
			fill_q <= {fill_q[1:0], 1'b1};
			rise   <= armed ? (sync_q & ~prev_q) : '0;
			fall   <= armed ? (~sync_q & prev_q) : '0;
		end
	end

	assign level = prev_q;

endmodule : sew_pin_sync

// >>> verilog/sew_pkg.sv
// Purpose: Shared constants and types of the two-wire serial EEPROM slave.
// Assumes: A 25 MHz system clock.
// Notes:   All offsets, field positions, reset values and timing counts live here.
package sew_pkg;

	localparam int              MCLK_FREQ_KHZ = 25000;
	localparam int              PROG_TIME_MS  = 10;
	localparam int              PROG_CYCLES   = PROG_TIME_MS * MCLK_FREQ_KHZ;
	localparam int              SPAN_FACTOR   = 2;

	localparam int              ADDR_W        = 8;
	localparam int              DATA_W        = 8;
	localparam int              MEM_DEPTH     = 256;
	localparam int              ROW_BYTES     = 8;
	localparam int              ROW_IDX_W     = 3;
	localparam logic [7:0]      MEM_RESET_VAL = 8'hFF;

	// Device type code: the value is arbitrary.
	localparam logic [3:0]      DEV_TYPE_CODE = 4'h5;

	localparam int              REG_ADDR_W    = 8;
	localparam int              REG_DATA_W    = 32;
	localparam logic [7:0]      REG_STATUS    = 8'h00;
	localparam logic [7:0]      REG_CTRL      = 8'h04;
	localparam int              STAT_BUSY_BIT = 0;
	localparam int              STAT_PROT_BIT = 1;
	localparam int              STAT_MODE_BIT = 2;
	localparam int              STAT_ST_LSB   = 4;
	localparam int              STAT_ADDR_LSB = 8;
	localparam int              CTRL_PROT_BIT = 0;
	localparam logic            CTRL_PROT_RST = 1'b0;

	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       mode;
		logic       prot;
		logic [2:0] chipSel;
	} sew_pins_s;

	localparam int              PIN_W         = $bits(sew_pins_s);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_RXEND,
		ST_ACK,
		ST_TX,
		ST_RACK,
		ST_PROG
	} sew_state_e;

	typedef enum logic [1:0] {
		BY_DEVSEL,
		BY_ADDR,
		BY_DATA
	} sew_byte_e;

endpackage : sew_pkg

// >>> verilog/sew_top.sv
// Purpose: Slave command logic of a 256-byte two-wire serial EEPROM.
// Assumes: The bus master drives the serial clock; mclk samples every pin.
// Notes:   Write bytes sit in an eight-entry latch until the timed program cycle.
// Behaviour
// [R01] Select byte: type code, chip-select match, direction bit; acknowledge on match.
// [R02] Mode pin high selects multibyte writing, low selects page writing.
// [R03] Write starts with select byte, then one acknowledged eight-bit address.
// [R04] Write protect high leaves the memory array unchanged.
// [R05] Single byte write works identically in both modes, ended by stop.
// [R06] Multibyte write starts anywhere, one to four bytes acknowledged each.
// [R07] Multibyte program takes the base time, doubled when bytes span rows.
// [R08] Master sends at most four multibyte bytes unless starting a row.
// [R09] Page write takes up to eight bytes of one row, one cycle.
// [R10] Page write increments only the low three address bits, wrapping.
// [R11] Stop after a write starts the self-timed program cycle.
// [R12] While programming, every bus input is ignored, nothing is acknowledged.
// [R13] Polling select bytes get no acknowledge while busy, acknowledge afterwards.
// [R14] Reads ignore the mode pin; every location starts as all ones.
// [R15] Current read returns byte at counter, then increments the counter.
// [R16] Random read: dummy write loads address, repeated start, read byte.
// [R17] Both select bytes of a random read carry the same upper bits.
// [R18] Acknowledged read bytes are followed by the next address byte.
// [R19] Read counter wraps from the top address to zero and continues.
// [R20] A missing acknowledge in the ninth read bit ends the transfer.
`timescale 1ns/10ps
module sew_top
	import sew_pkg::*;
#(
	parameter int PROG_TIME_CYC = PROG_CYCLES
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  scl,
	input  wire logic                  sdaIn,
	output logic                       sdaOut,
	output logic                       sdaOe,
	input  wire logic [2:0]            chipSelect,
	input  wire logic                  writeModeSel,
	input  wire logic                  writeProtect,
	input  wire logic [REG_ADDR_W-1:0] regAddr,
	input  wire logic [REG_DATA_W-1:0] regWrData,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic      [REG_DATA_W-1:0] regRdData
);

	localparam int TIMER_W = $clog2(PROG_TIME_CYC * SPAN_FACTOR + 1);
	localparam logic [TIMER_W-1:0] TIME_ONE_ROW = TIMER_W'(PROG_TIME_CYC);
	localparam logic [TIMER_W-1:0] TIME_TWO_ROW = TIMER_W'(PROG_TIME_CYC * SPAN_FACTOR);
	localparam logic [TIMER_W-1:0] TIME_LAST    = TIMER_W'(1);

	if (PROG_TIME_CYC < 1) begin : gBadProgTime
		$error("sew_top: PROG_TIME_CYC must be at least one cycle.");
	end

	sew_pins_s                  pinRaw;
	sew_pins_s                  pinLvl;
	sew_pins_s                  pinRise;
	sew_pins_s                  pinFall;
	sew_state_e                 state_q;
	sew_state_e                 state_d;
	sew_byte_e                  byteSel_q;
	sew_byte_e                  byteSel_d;
	logic [2:0]                 bitCnt_q;
	logic [2:0]                 bitCnt_d;
	logic [7:0]                 shift_q;
	logic [7:0]                 shift_d;
	logic [7:0]                 tx_q;
	logic [7:0]                 tx_d;
	logic                       rw_q;
	logic                       rw_d;
	logic [ADDR_W-1:0]          addr_q;
	logic [ADDR_W-1:0]          addr_d;
	logic                       oe_q;
	logic                       oe_d;
	logic [TIMER_W-1:0]         timer_q;
	logic [TIMER_W-1:0]         timer_d;
	logic                       softProt_q;
	logic [REG_DATA_W-1:0]      rdData_q;
	logic [DATA_W-1:0]          mem_q [MEM_DEPTH];
	logic [ROW_BYTES-1:0]       entValid_q;
	logic [ADDR_W-1:0]          entAddr_q [ROW_BYTES];
	logic [DATA_W-1:0]          entData_q [ROW_BYTES];
	logic [ADDR_W-ROW_IDX_W-1:0] firstRow_q;
	logic                       span_q;
	logic                       commit;
	logic                       latch;
	logic                       clearEnt;

	wire                        startSeen  = pinFall.sda & pinLvl.scl;
	wire                        stopSeen   = pinRise.sda & pinLvl.scl;
	wire                        sclRise    = pinRise.scl;
	wire                        sclFall    = pinFall.scl;
	wire                        protNow    = pinLvl.prot | softProt_q;
	wire                        modeMulti  = pinLvl.mode;
	wire                        anyEnt     = |entValid_q;
	wire                        selMatch   = (shift_q[7:4] == DEV_TYPE_CODE) &&
	                                         (shift_q[3:1] == pinLvl.chipSel);
	wire [ROW_IDX_W-1:0]        entIdx     = addr_q[ROW_IDX_W-1:0];
	wire [ROW_IDX_W-1:0]        pageLow    = addr_q[ROW_IDX_W-1:0] + 3'h1;
	wire [ADDR_W-1:0]           addrPage   = {addr_q[ADDR_W-1:ROW_IDX_W], pageLow};
	wire [ADDR_W-1:0]           addrLinear = addr_q + 8'h01;
	wire [ADDR_W-1:0]           addrWrNext = modeMulti ? addrLinear : addrPage;
	wire                        newRow     = addr_q[ADDR_W-1:ROW_IDX_W] != firstRow_q;
	wire [DATA_W-1:0]           memRdByte  = mem_q[addr_q];
	wire                        regWrCtrl  = regWr && (regAddr == REG_CTRL);
	wire [REG_DATA_W-1:0]       statusWord;
	wire [REG_DATA_W-1:0]       ctrlWord;
	wire [REG_DATA_W-1:0]       rdSel;

	assign pinRaw = '{scl: scl, sda: sdaIn, mode: writeModeSel, prot: writeProtect,
	                  chipSel: chipSelect};

	sew_pin_sync #(
		.W (PIN_W)
	) uPinSync (
		.mclk  (mclk),
		.rst   (rst),
		.din   (pinRaw),
		.level (pinLvl),
		.rise  (pinRise),
		.fall  (pinFall)
	);

	always_comb begin
		state_d   = state_q;
		byteSel_d = byteSel_q;
		bitCnt_d  = bitCnt_q;
		shift_d   = shift_q;
		tx_d      = tx_q;
		rw_d      = rw_q;
		addr_d    = addr_q;
		oe_d      = oe_q;
		timer_d   = timer_q;
		commit    = 1'b0;
		latch     = 1'b0;
		clearEnt  = 1'b0;
		if (state_q == ST_PROG) begin
			// Bus pins are not looked at until the program cycle ends.
			oe_d = 1'b0; // see [R12] see [R13]
			if (timer_q == TIME_LAST) begin
				commit  = 1'b1;
				state_d = ST_IDLE;
			end else begin
				timer_d = timer_q - TIME_LAST;
			end
		end else if (startSeen) begin
			state_d   = ST_RX;
			byteSel_d = BY_DEVSEL;
			bitCnt_d  = 3'h0;
			oe_d      = 1'b0;
			clearEnt  = 1'b1;
		end else if (stopSeen) begin
			oe_d = 1'b0;
			if (anyEnt && !protNow) begin
				state_d = ST_PROG; // see [R11]
				timer_d = span_q ? TIME_TWO_ROW : TIME_ONE_ROW; // see [R07]
			end else begin
				state_d  = ST_IDLE; // see [R04]
				clearEnt = 1'b1;
			end
		end else begin
			case (state_q)
				ST_RX: begin
					if (sclRise) begin
						shift_d  = {shift_q[6:0], pinLvl.sda};
						bitCnt_d = bitCnt_q + 3'h1;
						if (bitCnt_q == 3'h7) begin
							state_d = ST_RXEND;
						end
					end
				end
				ST_RXEND: begin
					if (sclFall) begin
						case (byteSel_q)
							BY_DEVSEL: begin
								if (selMatch) begin
									oe_d    = 1'b1; // see [R01]
									rw_d    = shift_q[0];
									state_d = ST_ACK;
								end else begin
									state_d = ST_IDLE;
								end
							end
							BY_ADDR: begin
								addr_d  = shift_q; // see [R03] see [R16]
								oe_d    = 1'b1;
								state_d = ST_ACK;
							end
							default: begin
								latch   = !protNow; // see [R04]
								addr_d  = addrWrNext; // see [R02] see [R06] see [R10]
								oe_d    = 1'b1; // see [R05] see [R09]
								state_d = ST_ACK;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (sclFall) begin
						bitCnt_d = 3'h0;
						if (rw_q) begin
							tx_d    = {memRdByte[6:0], 1'b1}; // see [R15] see [R18]
							oe_d    = ~memRdByte[7];
							addr_d  = addrLinear; // see [R14] see [R19]
							state_d = ST_TX;
						end else begin
							oe_d      = 1'b0;
							byteSel_d = (byteSel_q == BY_DEVSEL) ? BY_ADDR : BY_DATA;
							state_d   = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (sclFall) begin
						bitCnt_d = bitCnt_q + 3'h1;
						if (bitCnt_q == 3'h7) begin
							oe_d    = 1'b0;
							state_d = ST_RACK;
						end else begin
							oe_d = ~tx_q[7];
							tx_d = {tx_q[6:0], 1'b1};
						end
					end
				end
				ST_RACK: begin
					if (sclRise) begin
						state_d = pinLvl.sda ? ST_IDLE : ST_ACK; // see [R20]
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q   <= ST_IDLE;
			byteSel_q <= BY_DEVSEL;
			bitCnt_q  <= 3'h0;
			shift_q   <= 8'h00;
			tx_q      <= 8'hFF;
			rw_q      <= 1'b0;
			addr_q    <= 8'h00;
			oe_q      <= 1'b0;
			timer_q   <= '0;
		end else begin
			state_q   <= state_d;
			byteSel_q <= byteSel_d;
			bitCnt_q  <= bitCnt_d;
			shift_q   <= shift_d;
			tx_q      <= tx_d;
			rw_q      <= rw_d;
			addr_q    <= addr_d;
			oe_q      <= oe_d;
			timer_q   <= timer_d;
		end
	end

	// Each latch entry is addressed by the low address bits, so page wrap overwrites.
	for (genvar k = 0; k < ROW_BYTES; k++) begin : gEntry
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				entValid_q[k] <= 1'b0;
				entAddr_q[k]  <= 8'h00;
				entData_q[k]  <= 8'h00;
			end else if (clearEnt || commit) begin
				entValid_q[k] <= 1'b0;
			end else if (latch && (entIdx == ROW_IDX_W'(k))) begin
				entValid_q[k] <= 1'b1; // see [R09] see [R10]
				entAddr_q[k]  <= addr_q;
				entData_q[k]  <= shift_q;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			firstRow_q <= '0;
			span_q     <= 1'b0;
		end else if (clearEnt || commit) begin
			span_q <= 1'b0;
		end else if (latch && !anyEnt) begin
			firstRow_q <= addr_q[ADDR_W-1:ROW_IDX_W];
		end else if (latch && modeMulti && newRow) begin
			span_q <= 1'b1; // see [R07]
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem_q[i] <= MEM_RESET_VAL; // see [R14]
			end
		end else if (commit) begin
			for (int k = 0; k < ROW_BYTES; k++) begin
				if (entValid_q[k]) begin
					mem_q[entAddr_q[k]] <= entData_q[k]; // see [R09]
				end
			end
		end
	end

	assign statusWord = REG_DATA_W'({addr_q, 1'b0, state_q, 1'b0, modeMulti, protNow,
	                                 state_q == ST_PROG});
	assign ctrlWord   = REG_DATA_W'(softProt_q);
	assign rdSel      = (regAddr == REG_STATUS) ? statusWord :
	                    (regAddr == REG_CTRL)   ? ctrlWord   : '0;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			softProt_q <= CTRL_PROT_RST;
		end else if (regWrCtrl) begin
			softProt_q <= regWrData[CTRL_PROT_BIT];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdData_q <= '0;
		end else begin
			rdData_q <= regRd ? rdSel : '0;
		end
	end

	assign regRdData = rdData_q;
	assign sdaOe     = oe_q;
	assign sdaOut    = 1'b0;

endmodule : sew_top
